/* include/fps_pkg.sv */
// Constants and types shared by the float and halfword store decoder
package fps_pkg;
  // Instruction field positions, bit 31 of the word is the first opcode bit
  localparam int OPC_LO = 26;
  localparam int SOURCE_GPR_LO = 21;
  localparam int BASE_GPR_LO   = 16;
  localparam int INDEX_GPR_LO  = 11;
  localparam int XO_LO  = 1;
  // Primary opcodes
  localparam logic [5:0] OPC_STFS  = 6'h34;
  localparam logic [5:0] OPC_STFSU = 6'h35;
  localparam logic [5:0] OPC_STH   = 6'h2C;
  localparam logic [5:0] OPC_STHU  = 6'h2D;
  localparam logic [5:0] OPC_STMW  = 6'h2F;
  localparam logic [5:0] OPC_EXT   = 6'h1F;
  // Extended opcodes under the indexed primary opcode
  localparam logic [9:0] XO_RAW_WORD = 10'h3D7;
  localparam logic [9:0] XO_STFSUX   = 10'h2B7;
  localparam logic [9:0] XO_STFSX    = 10'h297;
  localparam logic [9:0] XO_STHBRX   = 10'h396;
  localparam logic [9:0] XO_STHUX    = 10'h1B7;
  localparam logic [9:0] XO_STHX     = 10'h197;
  // Access sizes in bytes
  localparam logic [2:0] SIZE_HALF = 3'h2;
  localparam logic [2:0] SIZE_WORD = 3'h4;
  // Store multiple stepping
  localparam logic [4:0]  LAST_GPR  = 5'h1F;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // Double to single conversion limits on the biased exponent
  localparam logic [10:0] EXP_NORM_MIN   = 11'h380;
  localparam logic [10:0] EXP_DENORM_MIN = 11'h36A;
  localparam logic [10:0] EXP_SHIFT_BASE = 11'h381;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0]  RST_REG  = 5'h00;
  localparam logic [2:0]  RST_SIZE = 3'h0;
  // Store data formats
  typedef enum logic [2:0] {KIND_RAW, KIND_SINGLE, KIND_HALF, KIND_HALF_REV, KIND_WORD} fps_kind_e;
endpackage

/* include/fps_fmt_if.sv */
// Carrier between the decoder and its store data formatter
`timescale 1ns/1ns
interface fps_fmt_if;
  fps_pkg::fps_kind_e kind;
  logic [31:0]        gpr;
  logic [63:0]        fpr;
  logic [31:0]        data;
  logic [2:0]         size;
  modport req (output kind, output gpr, output fpr, input data, input size);
  modport fmt (input kind, input gpr, input fpr, output data, output size);
endinterface

/* core/fps_fmt.sv */
// Store data formatter: raw word, single conversion, halfword lanes
`timescale 1ns/1ns
module fps_fmt (
  fps_fmt_if.fmt f  // Format request and result
);
  // Double register image to single word, with denormalisation
  function automatic logic [31:0] to_single(input logic [63:0] v);
    logic [23:0] mant;
    logic [10:0] sh;
    mant = {1'b1, v[51:29]};
    sh = fps_pkg::EXP_SHIFT_BASE - v[62:52];
    to_single = {v[63:62], v[58:29]};
    if (v[62:52] <= fps_pkg::EXP_NORM_MIN && v[62:52] >= fps_pkg::EXP_DENORM_MIN)
    begin
      mant = mant >> sh[4:0];
      to_single = {v[63], 8'h00, mant[22:0]};
    end
  endfunction

  // Lane selection, first memory byte sits in the high lane
  always_comb
  begin
    f.data = f.gpr;
    f.size = fps_pkg::SIZE_WORD;
    case (f.kind)
      fps_pkg::KIND_RAW:      f.data = f.fpr[31:0];           // No conversion
      fps_pkg::KIND_SINGLE:   f.data = to_single(f.fpr);
      fps_pkg::KIND_HALF:
      begin
        f.data = {16'h0000, f.gpr[15:0]};
        f.size = fps_pkg::SIZE_HALF;
      end
      fps_pkg::KIND_HALF_REV:
      begin
        f.data = {16'h0000, f.gpr[7:0], f.gpr[15:8]};
        f.size = fps_pkg::SIZE_HALF;
      end
      default:                f.data = f.gpr;
    endcase
  end
endmodule // fps_fmt

/* core/fps_store_top.sv */
// Decoder and sequencer for float single, raw word, halfword and multiple stores
`timescale 1ns/1ns
module fps_store_top (
  input  wire logic        CLK_SYS,      // Core clock, 20 MHz
  input  wire logic        RESETN,       // Asynchronous reset, active low
  input  wire logic        CE,           // Clock enable, freezes state when low
  input  wire logic        INSTR_VALID,  // Instruction offered
  input  wire logic [31:0] INSTR,        // Instruction word
  input  wire logic [31:0] OP_BASE,      // Contents of base_gpr
  input  wire logic [31:0] OP_INDEX,     // Contents of index_gpr
  input  wire logic [31:0] OP_SRC,       // Contents of source_gpr
  input  wire logic [63:0] OP_FSRC,      // Contents of float_source_reg
  input  wire logic [31:0] GPR_RDATA,    // Register file data for GPR_RADDR
  input  wire logic        ST_READY,     // Memory pipeline takes the store
  output logic             INSTR_READY,  // Decoder can take an instruction
  output logic             ST_VALID,     // Store request held
  output logic      [31:0] ST_ADDR,      // effective_addr of the store
  output logic      [31:0] ST_DATA,      // Store data, low lanes used
  output logic      [2:0]  ST_SIZE,      // Bytes to store
  output logic             WB_VALID,     // Base writeback pulse
  output logic      [4:0]  WB_REG,       // Base register number
  output logic      [31:0] WB_DATA,      // Address written back
  output logic             ILLEGAL,      // Invalid form pulse
  output logic             ALIGN_EXC,    // Alignment exception pulse
  output logic      [4:0]  GPR_RADDR     // Register file read address
);
  typedef enum logic [1:0] {S_IDLE, S_STORE, S_MRD, S_MST} fps_state_e;

  logic        rst_meta;
  logic        rst_n;
  fps_state_e  state;
  logic        ready;
  logic        st_valid;
  logic [31:0] st_addr;
  logic [31:0] st_data;
  logic [2:0]  st_size;
  logic        wb_valid;
  logic [4:0]  wb_reg;
  logic [31:0] wb_data;
  logic        illegal;
  logic        align_exc;
  logic [4:0]  gpr_raddr;
  logic [5:0]  opc;
  logic [4:0]  source_gpr;
  logic [4:0]  base_gpr;
  logic [9:0]  xo;
  logic        dec_known;
  logic        dec_upd;
  logic        dec_idx;
  logic        dec_multi;
  fps_pkg::fps_kind_e dec_kind;
  logic [31:0] base_val;
  logic [31:0] effective_addr;
  logic        acc;
  logic        bad_form;
  logic        take_bad;
  logic        take_one;
  logic        take_multi;
  logic        take_mis;
  logic        done_st;
  logic        fetch;

  fps_fmt_if fif ();

  // Field extraction, lo is the lowest field bit, numbered from the least significant bit
  function automatic logic [4:0] reg_field(input logic [31:0] w, input int lo);
    reg_field = w[lo +: 5];
  endfunction

  // Displacement to address width
  function automatic logic [31:0] sign_extend(input logic [15:0] d);
    sign_extend = {{16{d[15]}}, d};
  endfunction

  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Opcode decode
  always_comb
  begin
    opc       = INSTR[fps_pkg::OPC_LO +: 6];
    source_gpr = reg_field(INSTR, fps_pkg::SOURCE_GPR_LO);
    base_gpr  = reg_field(INSTR, fps_pkg::BASE_GPR_LO);
    xo        = INSTR[fps_pkg::XO_LO +: 10];
    dec_known = 1'b1;
    dec_upd   = 1'b0;
    dec_idx   = 1'b0;
    dec_multi = 1'b0;
    dec_kind  = fps_pkg::KIND_WORD;
    case (opc)
      fps_pkg::OPC_STFS:  dec_kind = fps_pkg::KIND_SINGLE;
      fps_pkg::OPC_STFSU:
      begin
        dec_kind = fps_pkg::KIND_SINGLE;
        dec_upd  = 1'b1;
      end
      fps_pkg::OPC_STH:   dec_kind = fps_pkg::KIND_HALF;
      fps_pkg::OPC_STHU:
      begin
        dec_kind = fps_pkg::KIND_HALF;
        dec_upd  = 1'b1;
      end
      fps_pkg::OPC_STMW:  dec_multi = 1'b1;
      fps_pkg::OPC_EXT:
      begin
        dec_idx   = 1'b1;
        dec_known = ~INSTR[0];                                // Reserved bit zero
        case (xo)
          fps_pkg::XO_RAW_WORD: dec_kind = fps_pkg::KIND_RAW;
          fps_pkg::XO_STFSX:    dec_kind = fps_pkg::KIND_SINGLE;
          fps_pkg::XO_STFSUX:
          begin
            dec_kind = fps_pkg::KIND_SINGLE;
            dec_upd  = 1'b1;
          end
          fps_pkg::XO_STHX:     dec_kind = fps_pkg::KIND_HALF;
          fps_pkg::XO_STHBRX:   dec_kind = fps_pkg::KIND_HALF_REV;
          fps_pkg::XO_STHUX:
          begin
            dec_kind = fps_pkg::KIND_HALF;
            dec_upd  = 1'b1;
          end
          default:              dec_known = 1'b0;
        endcase
      end
      default:            dec_known = 1'b0;
    endcase
  end

  // Effective address: zero substitution only on non-update forms
  always_comb
  begin
    base_val = (base_gpr == 5'h00 && !dec_upd) ? fps_pkg::RST_WORD : OP_BASE;
    effective_addr = base_val + (dec_idx ? OP_INDEX : sign_extend(INSTR[15:0]));
  end

  // Acceptance conditions
  assign acc        = CE & INSTR_VALID & ready;
  assign bad_form   = ~dec_known | (dec_upd & (base_gpr == 5'h00));
  assign take_bad   = acc & bad_form;
  assign take_one   = acc & ~bad_form & ~dec_multi;
  assign take_multi = acc & ~bad_form & dec_multi & (effective_addr[1:0] == 2'b00);
  assign take_mis   = acc & ~bad_form & dec_multi & (effective_addr[1:0] != 2'b00);
  assign done_st    = CE & st_valid & ST_READY;
  assign fetch      = CE & (state == S_MRD);

  // Formatter request: multiple store data comes from the register file
  assign fif.kind = fetch ? fps_pkg::KIND_WORD : dec_kind;
  assign fif.gpr  = fetch ? GPR_RDATA : OP_SRC;
  assign fif.fpr  = OP_FSRC;

  fps_fmt u_fmt (
    .f (fif.fmt)
  );

  // Sequencer state and instruction handshake
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= S_IDLE;
      ready     <= 1'b0;
      gpr_raddr <= fps_pkg::RST_REG;
    end
    else if (CE)
    begin
      case (state)
        S_IDLE:
        begin
          ready <= ~(take_one | take_multi);
          if (take_one)
            state <= S_STORE;
          else if (take_multi)
          begin
            state     <= S_MRD;
            gpr_raddr <= source_gpr;
          end
        end
        S_STORE:
          if (done_st)
          begin
            state <= S_IDLE;
            ready <= 1'b1;
          end
        S_MRD:    state <= S_MST;
        S_MST:
          if (done_st)
          begin
            if (gpr_raddr == fps_pkg::LAST_GPR)
            begin
              state <= S_IDLE;
              ready <= 1'b1;
            end
            else
            begin
              state     <= S_MRD;
              gpr_raddr <= gpr_raddr + 5'h01;
            end
          end
        default:  state <= S_IDLE;
      endcase
    end
  end

  // Store request towards the memory pipeline
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_valid <= 1'b0;
      st_addr  <= fps_pkg::RST_WORD;
      st_data  <= fps_pkg::RST_WORD;
      st_size  <= fps_pkg::RST_SIZE;
    end
    else if (CE)
    begin
      if (take_one | fetch)
      begin
        st_valid <= 1'b1;
        st_data  <= fif.data;
        st_size  <= fif.size;
      end
      else if (done_st)
        st_valid <= 1'b0;
      if (take_one | take_multi)
        st_addr <= effective_addr;
      else if (done_st && state == S_MST && gpr_raddr != fps_pkg::LAST_GPR)
        st_addr <= st_addr + fps_pkg::WORD_STEP;
    end
  end

  // Base register writeback for update forms
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_valid <= 1'b0;
      wb_reg   <= fps_pkg::RST_REG;
      wb_data  <= fps_pkg::RST_WORD;
    end
    else if (CE)
    begin
      wb_valid <= take_one & dec_upd;
      if (take_one & dec_upd)
      begin
        wb_reg  <= base_gpr;
        wb_data <= effective_addr;
      end
    end
  end

  // Exception pulses
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      illegal   <= 1'b0;
      align_exc <= 1'b0;
    end
    else if (CE)
    begin
      illegal   <= take_bad;
      align_exc <= take_mis;
    end
  end

  // Outputs straight from flops
  assign INSTR_READY = ready;
  assign ST_VALID    = st_valid;
  assign ST_ADDR     = st_addr;
  assign ST_DATA     = st_data;
  assign ST_SIZE     = st_size;
  assign WB_VALID    = wb_valid;
  assign WB_REG      = wb_reg;
  assign WB_DATA     = wb_data;
  assign ILLEGAL     = illegal;
  assign ALIGN_EXC   = align_exc;
  assign GPR_RADDR   = gpr_raddr;

  // Checks on decode, data and sequencing
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  AST_RAW_WORD: assert property (
    take_one && dec_kind == fps_pkg::KIND_RAW |=> st_data == $past(OP_FSRC[31:0]) && st_size == 3'h4)
    else $error("Raw word store data wrong");
  AST_SINGLE_FMT: assert property (
    take_one && dec_kind == fps_pkg::KIND_SINGLE && OP_FSRC[62:52] > 11'h380
    |=> st_data == {$past(OP_FSRC[63:62]), $past(OP_FSRC[58:29])})
    else $error("Single conversion wrong");
  AST_ZERO_BASE: assert property (
    take_one && opc == fps_pkg::OPC_STFS && base_gpr == 5'h00
    |=> st_valid && st_addr == $past(sign_extend(INSTR[15:0])))
    else $error("Zero base not substituted");
  AST_UPD_WB: assert property (
    take_one && dec_upd
    |=> wb_valid && wb_reg == $past(base_gpr) && wb_data == st_addr ##1 !wb_valid)
    else $error("Update writeback wrong");
  AST_INVALID: assert property (
    acc && dec_upd && base_gpr == 5'h00 |=> illegal && !st_valid && !wb_valid && ready)
    else $error("Invalid update form not rejected");
  AST_BYTE_REV: assert property (
    take_one && dec_kind == fps_pkg::KIND_HALF_REV
    |=> st_data[15:0] == {$past(OP_SRC[7:0]), $past(OP_SRC[15:8])} && st_size == 3'h2)
    else $error("Byte reversed halfword wrong");
  AST_IDX_NOWB: assert property (
    take_one && !dec_upd |=> !wb_valid)
    else $error("Writeback on non-update form");
  AST_MULTI_STEP: assert property (
    done_st && state == S_MST && gpr_raddr != 5'h1F
    |=> state == S_MRD && st_addr == $past(st_addr) + 32'h0000_0004 && !st_valid)
    else $error("Multiple store did not advance");
  AST_MULTI_END: assert property (
    done_st && state == S_MST && gpr_raddr == 5'h1F |=> state == S_IDLE && ready)
    else $error("Multiple store did not end at last register");
  AST_ALIGN: assert property (
    take_mis |=> align_exc && !st_valid && ready)
    else $error("Misaligned multiple store not trapped");
  AST_MULTI_SIZE: assert property (
    state == S_MST && st_valid |-> st_size == 3'h4)
    else $error("Multiple store size not a word");

  COV_HALF:  cover property (take_one && dec_kind == fps_pkg::KIND_HALF ##[1:4] done_st);
  COV_UPD:   cover property (take_one && dec_upd ##1 wb_valid);
  COV_MULTI: cover property (take_multi && source_gpr == 5'h1E ##[4:40] state == S_IDLE);
  COV_BAD:   cover property (take_bad ##1 illegal);
endmodule // fps_store_top

/* verif/fps_mem_model.sv */
// Memory pipeline and register file model facing the store decoder
`timescale 1ns/1ns
module fps_mem_model (
  input  wire logic        clk,        // Core clock
  input  wire logic        rst_n,      // Bench reset, active low
  input  wire logic        st_valid,   // Store request
  input  wire logic [31:0] st_addr,    // Store address
  input  wire logic [31:0] st_data,    // Store data
  input  wire logic [2:0]  st_size,    // Store size
  input  wire logic [4:0]  gpr_raddr,  // Register read address
  input  wire logic [3:0]  stall,      // Wait cycles before accepting
  output logic             st_ready,   // Store accepted
  output logic      [31:0] gpr_rdata,  // Register read data
  output logic      [31:0] acc_addr,   // Last accepted address
  output logic      [31:0] acc_data,   // Last accepted data
  output logic      [2:0]  acc_size,   // Last accepted size
  output int               acc_cnt     // Stores accepted
);
  logic [3:0] wait_cnt;
  // Register file image, distinct value per register
  assign gpr_rdata = 32'h5A00_0000 | {27'h000_0000, gpr_raddr};
  // Accept only after the requested number of wait cycles
  assign st_ready = st_valid && (wait_cnt >= stall);
  // Wait cycles of the pending request
  always_ff @(posedge clk)
  begin
    if (!st_valid || st_ready)
      wait_cnt <= 4'h0;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
  // Capture of every accepted store
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_cnt <= 0;
    else if (st_valid && st_ready)
    begin
      acc_addr <= st_addr;
      acc_data <= st_data;
      acc_size <= st_size;
      acc_cnt  <= acc_cnt + 1;
    end
  end
endmodule // fps_mem_model

/* verif/test_fp_single_and_halfword_store_decode.sv */
// Self-checking bench for the float and halfword store decoder
`timescale 1ns/1ns
module test_fp_single_and_halfword_store_decode;
  logic clk_sys, resetn, ce, instr_valid, st_ready, instr_ready, st_valid;
  logic wb_valid, illegal, align_exc;
  logic [31:0] instr, op_base, op_index, op_src, gpr_rdata, st_addr, st_data;
  logic [31:0] wb_data, acc_addr, acc_data;
  logic [63:0] op_fsrc;
  logic [4:0]  wb_reg, gpr_raddr;
  logic [2:0]  st_size, acc_size;
  logic [3:0]  stall;
  int          acc_cnt, error_cnt, total_checks;

  fps_store_top dut (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .INSTR_VALID(instr_valid),
    .INSTR(instr), .OP_BASE(op_base), .OP_INDEX(op_index), .OP_SRC(op_src),
    .OP_FSRC(op_fsrc), .GPR_RDATA(gpr_rdata), .ST_READY(st_ready),
    .INSTR_READY(instr_ready), .ST_VALID(st_valid), .ST_ADDR(st_addr), .ST_DATA(st_data),
    .ST_SIZE(st_size), .WB_VALID(wb_valid), .WB_REG(wb_reg), .WB_DATA(wb_data),
    .ILLEGAL(illegal), .ALIGN_EXC(align_exc), .GPR_RADDR(gpr_raddr));
  fps_mem_model mem (.clk(clk_sys), .rst_n(resetn), .st_valid(st_valid), .st_addr(st_addr),
    .st_data(st_data), .st_size(st_size), .gpr_raddr(gpr_raddr), .stall(stall),
    .st_ready(st_ready), .gpr_rdata(gpr_rdata), .acc_addr(acc_addr), .acc_data(acc_data),
    .acc_size(acc_size), .acc_cnt(acc_cnt));

  // Clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  // Compare tasks for words and for flags
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Instruction word builders
  function automatic logic [31:0] mk_d(input logic [5:0] opc, input logic [4:0] src,
                                       input logic [4:0] base, input logic [15:0] d);
    return {opc, src, base, d};
  endfunction
  function automatic logic [31:0] mk_x(input logic [4:0] src, input logic [4:0] base,
                                       input logic [4:0] idx, input logic [9:0] xo);
    return {fps_pkg::OPC_EXT, src, base, idx, xo, 1'b0};
  endfunction

  // Offer one instruction, return at the falling edge after it is taken
  task automatic issue(input logic [31:0] ins, input logic [31:0] base, input logic [31:0] idx,
                       input logic [31:0] src, input logic [63:0] fsrc);
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_flag(instr_ready, 1'b1, "decoder ready for instruction");
    instr = ins;
    op_base = base;
    op_index = idx;
    op_src = src;
    op_fsrc = fsrc;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
  endtask

  // Bounded wait for the decoder to become free again
  task automatic wait_idle;
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_flag(instr_ready, 1'b1, "decoder free again");
  endtask

  // One single store with its expected address, data, size and writeback
  task automatic run_store(input logic [31:0] ins, input logic [31:0] base,
                           input logic [31:0] idx, input logic [31:0] src,
                           input logic [63:0] fsrc, input logic [31:0] addr,
                           input logic [31:0] dat, input logic [2:0] sz, input logic wb);
    int c0;
    c0 = acc_cnt;
    issue(ins, base, idx, src, fsrc);
    chk_flag(wb_valid, wb, "writeback pulse");
    if (wb)
    begin
      chk_val(wb_data, addr, "writeback address");
      chk_val({27'h000_0000, wb_reg}, {27'h000_0000, ins[20:16]}, "writeback register");
    end
    wait_idle();
    chk_val(acc_addr, addr, "store address");
    chk_val(acc_data, dat, "store data");
    chk_val({29'h0000_0000, acc_size}, {29'h0000_0000, sz}, "store size");
    chk_val(acc_cnt - c0, 32'h0000_0001, "store count");
  endtask

  // Raw word float store, no conversion
  task automatic t_raw;
    run_store(mk_x(5'h03, 5'h00, 5'h04, fps_pkg::XO_RAW_WORD), 32'h1234_0000, 32'h0000_2000,
      32'h0, 64'h4009_21FB_5444_2D18, 32'h0000_2000, 32'h5444_2D18, 3'h4, 1'b0);
    run_store(mk_x(5'h03, 5'h02, 5'h04, fps_pkg::XO_RAW_WORD), 32'h0000_0100, 32'h0000_0010,
      32'h0, 64'h3FF0_0000_0000_0000, 32'h0000_0110, 32'h0000_0000, 3'h4, 1'b0);
    $display("test raw word done");
  endtask

  // Single stores with displacement and index, displacement forms with stalls
  task automatic t_single;
    stall = 4'h3;
    run_store(mk_d(fps_pkg::OPC_STFS, 5'h01, 5'h05, 16'hFFF8), 32'h0000_1000, 32'h0, 32'h0,
      64'h3FF0_0000_0000_0000, 32'h0000_0FF8, 32'h3F80_0000, 3'h4, 1'b0);
    run_store(mk_d(fps_pkg::OPC_STFS, 5'h01, 5'h00, 16'h0010), 32'h7000_0000, 32'h0, 32'h0,
      64'hC004_0000_0000_0000, 32'h0000_0010, 32'hC020_0000, 3'h4, 1'b0);
    run_store(mk_d(fps_pkg::OPC_STFSU, 5'h01, 5'h07, 16'h0020), 32'h0000_2000, 32'h0, 32'h0,
      64'h3FF0_0000_0000_0000, 32'h0000_2020, 32'h3F80_0000, 3'h4, 1'b1);
    stall = 4'h0;
    run_store(mk_x(5'h01, 5'h08, 5'h02, fps_pkg::XO_STFSUX), 32'h0000_3000, 32'h0000_0044,
      32'h0, 64'hC004_0000_0000_0000, 32'h0000_3044, 32'hC020_0000, 3'h4, 1'b1);
    run_store(mk_x(5'h01, 5'h09, 5'h02, fps_pkg::XO_STFSX), 32'h0000_4000, 32'h0000_0008,
      32'h0, 64'h3FF0_0000_0000_0000, 32'h0000_4008, 32'h3F80_0000, 3'h4, 1'b0);
    run_store(mk_x(5'h01, 5'h09, 5'h02, fps_pkg::XO_STFSX), 32'h0000_4000, 32'h0000_0010,
      32'h0, 64'h36A0_0000_0000_0000, 32'h0000_4010, 32'h0000_0001, 3'h4, 1'b0);
    $display("test single stores done");
  endtask

  // All five halfword stores
  task automatic t_half;
    run_store(mk_d(fps_pkg::OPC_STH, 5'h06, 5'h00, 16'h0102), 32'h5555_0000, 32'h0,
      32'hAABB_CCDD, 64'h0, 32'h0000_0102, 32'h0000_CCDD, 3'h2, 1'b0);
    run_store(mk_x(5'h06, 5'h02, 5'h03, fps_pkg::XO_STHBRX), 32'h0000_0500, 32'h0000_0002,
      32'hAABB_CCDD, 64'h0, 32'h0000_0502, 32'h0000_DDCC, 3'h2, 1'b0);
    run_store(mk_d(fps_pkg::OPC_STHU, 5'h06, 5'h03, 16'hFFFE), 32'h0000_0600, 32'h0,
      32'h1122_3344, 64'h0, 32'h0000_05FE, 32'h0000_3344, 3'h2, 1'b1);
    run_store(mk_x(5'h06, 5'h04, 5'h05, fps_pkg::XO_STHUX), 32'h0000_0700, 32'h0000_0010,
      32'h1122_3344, 64'h0, 32'h0000_0710, 32'h0000_3344, 3'h2, 1'b1);
    run_store(mk_x(5'h06, 5'h00, 5'h05, fps_pkg::XO_STHX), 32'h0000_0900, 32'h0000_0800,
      32'h1122_3344, 64'h0, 32'h0000_0800, 32'h0000_3344, 3'h2, 1'b0);
    $display("test halfword stores done");
  endtask

  // Update forms with base zero, a set reserved bit and an unknown extended opcode are refused
  task automatic t_invalid;
    logic [31:0] bad [6];
    int c0;
    bad = '{mk_d(fps_pkg::OPC_STFSU, 5'h01, 5'h00, 16'h0004),
            mk_x(5'h01, 5'h00, 5'h02, fps_pkg::XO_STFSUX),
            mk_d(fps_pkg::OPC_STHU, 5'h01, 5'h00, 16'h0004),
            mk_x(5'h01, 5'h00, 5'h02, fps_pkg::XO_STHUX),
            mk_x(5'h01, 5'h02, 5'h02, fps_pkg::XO_STFSX) | 32'h0000_0001,
            mk_x(5'h01, 5'h02, 5'h02, 10'h000)};
    c0 = acc_cnt;
    foreach (bad[i])
    begin
      issue(bad[i], 32'h0000_1000, 32'h0000_0010, 32'h0, 64'h0);
      chk_flag(illegal, 1'b1, "invalid form flagged");
      chk_flag(wb_valid, 1'b0, "no writeback on invalid form");
      chk_flag(instr_ready, 1'b1, "decoder stays free");
      @(negedge clk_sys);
    end
    repeat (3) @(negedge clk_sys);
    chk_val(acc_cnt - c0, 32'h0, "no store on invalid form");
    $display("test invalid forms done");
  endtask

  // Store multiple from a start register through 31, then a misaligned start
  task automatic t_multiple(input logic [4:0] sreg);
    int n;
    int c0;
    c0 = acc_cnt;
    issue(mk_d(fps_pkg::OPC_STMW, sreg, 5'h01, 16'h0008), 32'h0000_9000, 32'h0, 32'h0, 64'h0);
    for (int k = 0; k < 32 - sreg; k++)
    begin
      n = 0;
      while (st_valid !== 1'b1 && n < 20)
      begin
        @(negedge clk_sys);
        n++;
      end
      chk_val(st_addr, 32'h0000_9008 + 4 * k, "multiple address");
      chk_val(st_data, 32'h5A00_0000 | (sreg + k), "multiple data");
      chk_val({29'h0000_0000, st_size}, 32'h0000_0004, "multiple size");
      @(negedge clk_sys);
    end
    wait_idle();
    chk_val(acc_cnt - c0, 32 - sreg, "multiple word count");
    issue(mk_d(fps_pkg::OPC_STMW, sreg, 5'h01, 16'h0006), 32'h0000_9000, 32'h0, 32'h0, 64'h0);
    chk_flag(align_exc, 1'b1, "misaligned start flagged");
    repeat (3) @(negedge clk_sys);
    chk_val(acc_cnt - c0, 32 - sreg, "no store when misaligned");
    $display("test store multiple done");
  endtask

  // Clock enable low: an offered instruction is ignored, then taken when offered again once enabled
  task automatic t_freeze;
    int c0;
    c0 = acc_cnt;
    ce = 1'b0;
    issue(mk_d(fps_pkg::OPC_STH, 5'h06, 5'h00, 16'h0040), 32'h0, 32'h0, 32'h0000_BEEF, 64'h0);
    repeat (2) @(negedge clk_sys);
    chk_flag(st_valid, 1'b0, "no store while frozen");
    chk_val(acc_cnt - c0, 32'h0, "no store count while frozen");
    ce = 1'b1;
    run_store(mk_d(fps_pkg::OPC_STH, 5'h06, 5'h00, 16'h0040), 32'h0, 32'h0, 32'h0000_BEEF,
      64'h0, 32'h0000_0040, 32'h0000_BEEF, 3'h2, 1'b0);
    $display("test clock enable done");
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #(50 * 5000);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr = 32'h0;
    op_base = 32'h0;
    op_index = 32'h0;
    op_src = 32'h0;
    op_fsrc = 64'h0;
    stall = 4'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    t_raw();
    t_single();
    t_half();
    t_freeze();
    t_invalid();
    t_multiple(5'h1E);
    t_multiple(5'h1F);
    tally_and_finish();
  end
endmodule // test_fp_single_and_halfword_store_decode
